// File: include/ccc_pkg.sv
// ----------------------------------------------------------------
// constants of the capacitance converter control block
// ----------------------------------------------------------------
package ccc_pkg;
	// register byte offsets
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_RESULT = 12'h004;
	localparam logic [11:0] ADDR_STATE = 12'h008;
	localparam logic [11:0] ADDR_RES_SETUP = 12'h00c;
	localparam logic [11:0] ADDR_OFFSET_SETUP = 12'h010;
	localparam logic [11:0] ADDR_RANGE_SETUP = 12'h014;
	localparam logic [11:0] ADDR_MATRIX_A = 12'h018;
	localparam logic [11:0] ADDR_MATRIX_B = 12'h01c;
	localparam logic [11:0] ADDR_LOW_THR = 12'h020;
	localparam logic [11:0] ADDR_HIGH_THR = 12'h024;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h028;
	localparam logic [11:0] ADDR_IRQ_RAW = 12'h02c;
	localparam logic [11:0] ADDR_IRQ_ENABLED = 12'h030;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h034;

	// control register fields
	localparam int unsigned CTL_START_BIT = 0;
	localparam int unsigned CTL_STOP_BIT = 1;
	localparam int unsigned CTL_MODE_BIT = 2;
	// state register field
	localparam int unsigned STATE_CONFLICT_BIT = 7;
	// resolution field position and width
	localparam int unsigned RES_LSB = 1;
	localparam int unsigned RES_W = 3;
	// interrupt condition bits
	localparam int unsigned IRQ_READY_BIT = 0;
	localparam int unsigned IRQ_LOW_BIT = 1;
	localparam int unsigned IRQ_HIGH_BIT = 2;
	localparam int unsigned IRQ_W = 3;

	// field widths
	localparam int unsigned MATRIX_W = 17;
	localparam int unsigned RESULT_W = 16;
	localparam int unsigned OFFSET_W = 6;
	localparam int unsigned RANGE_W = 2;

	// reset values
	localparam logic [2:0] RST_CONTROL = 3'h0;
	localparam logic [2:0] RST_RES = 3'h0;
	localparam logic [5:0] RST_OFFSET = 6'h00;
	localparam logic [1:0] RST_RANGE = 2'h0;
	localparam logic [16:0] RST_MATRIX = 17'h0_0000;
	localparam logic [15:0] RST_THR = 16'h0000;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// sequencer states, gray coded
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_RUN = 2'h1
	} ccc_seq_state_t;

	// result width in bits for a resolution code: 8,10,11,..,16
	function automatic logic [4:0] res_bits(input logic [2:0] code);
		return (code == 3'h0) ? 5'h08 : (5'(code) + 5'h09);
	endfunction
endpackage

// File: include/ccc_conv_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link between sequencer and bit-density accumulator
// ----------------------------------------------------------------
interface ccc_conv_if;
	logic launch;
	logic [2:0] res_code;
	logic busy;
	logic done;
	logic [15:0] result;
	modport seq (output launch, output res_code, input busy, input done, input result);
	modport acc (input launch, input res_code, output busy, output done, output result);
endinterface

// File: core/ccc_accum.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bit-density accumulator: counts modulator ones over 2^bits cycles
// ----------------------------------------------------------------
module ccc_accum (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// modulator stream
	input wire logic mod_bit,
	// conversion link
	ccc_conv_if.acc conv
);
	logic [16:0] cnt_q;
	logic [16:0] ones_q;
	logic [16:0] last_cnt;
	logic [16:0] ones_d;
	logic [2:0] code_q;
	logic busy_q;
	logic done_q;
	logic [15:0] result_q;

	// widest code takes twice the cycles of the next one
	assign last_cnt = (17'h0_0001 << ccc_pkg::res_bits(code_q)) - 17'h0_0001;
	// ones count including this cycle's sample, so the last busy cycle is not lost
	assign ones_d = ones_q + {16'h0000, mod_bit};

	// cycle counter and ones counter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 17'h0_0000;
			ones_q <= 17'h0_0000;
			code_q <= 3'h0;
			busy_q <= 1'b0;
		end else if (conv.launch) begin
			cnt_q <= 17'h0_0000;
			ones_q <= 17'h0_0000;
			code_q <= conv.res_code;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			cnt_q <= cnt_q + 17'h0_0001;
			ones_q <= ones_d;
			if (cnt_q == last_cnt) begin
				busy_q <= 1'b0;
			end
		end
	end

	// result, saturated to sixteen bits
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
			result_q <= 16'h0000;
		end else begin
			done_q <= busy_q && !conv.launch && (cnt_q == last_cnt);
			if (busy_q && !conv.launch && (cnt_q == last_cnt)) begin
				result_q <= ones_d[16] ? 16'hffff : ones_d[15:0];
			end
		end
	end

	assign conv.busy = busy_q;
	assign conv.done = done_q;
	assign conv.result = result_q;

	property p_eight_bit_time;
		@(posedge core_clk) disable iff (!resetn)
		(conv.launch && conv.res_code == 3'h0 && !busy_q) |-> ##257 done_q;
	endproperty
	a_eight_bit_time: assert property (p_eight_bit_time) else $error("8-bit conversion time wrong");
endmodule

// File: core/ccc_seq.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// conversion sequencer: single-shot and continuous operation
// ----------------------------------------------------------------
module ccc_seq (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// control bits
	input wire logic start,
	input wire logic stop,
	input wire logic mode,
	input wire logic conflict,
	input wire logic [2:0] res_code,
	// end of measurement pulse
	output logic finish,
	// conversion link
	ccc_conv_if.seq conv
);
	ccc_pkg::ccc_seq_state_t state_q;
	logic launch_d;
	logic finish_d;
	logic again;

	// continuous mode keeps going unless stop or a conflict shows up
	assign again = mode && !stop && !conflict;

	always_comb begin
		launch_d = 1'b0;
		finish_d = 1'b0;
		case (state_q)
			ccc_pkg::SEQ_IDLE: launch_d = start && !conflict;
			ccc_pkg::SEQ_RUN: begin
				launch_d = conv.done && again;
				finish_d = conv.done && !again;
			end
			default: ;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ccc_pkg::SEQ_IDLE;
		end else begin
			case (state_q)
				ccc_pkg::SEQ_IDLE: if (launch_d) state_q <= ccc_pkg::SEQ_RUN;
				ccc_pkg::SEQ_RUN: if (finish_d) state_q <= ccc_pkg::SEQ_IDLE;
				default: state_q <= ccc_pkg::SEQ_IDLE;
			endcase
		end
	end

	assign conv.launch = launch_d;
	assign conv.res_code = res_code;
	assign finish = finish_d;
endmodule

// File: core/ccc_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// What this block does
// - start bit self-clears after measurement
// - stop halts continuous after current conversion
// - stop ignored in single-shot mode
// - mode bit: single-shot or continuous
// - reading result clears interrupt conditions
// - result unsigned in bits 15:0
// - state bit 7 flags matrix overlap
// - resolution code selects 8 to 16 bits
// - widest resolution doubles conversion time
// - two matrices feed ports A, B
// - pairs 0-2 external, 11-16 internal references
// - fourteen word registers, clear is write-only
// - matrix overlap refuses conversions
// - raw and enabled interrupt status views
// - threshold interrupts gated by enables
module ccc_ctrl (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// modulator bit stream
	input wire logic mod_bit,
	// analog settings
	output logic [16:0] port_a_sel,
	output logic [16:0] port_b_sel,
	output logic [5:0] offset_cap,
	output logic [1:0] range_cap,
	// status
	output logic conv_busy,
	output logic irq
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic start_q;
	logic stop_q;
	logic mode_q;
	logic [2:0] res_q;
	logic [5:0] offset_q;
	logic [1:0] range_q;
	logic [16:0] matrix_a_q;
	logic [16:0] matrix_b_q;
	logic [15:0] low_thr_q;
	logic [15:0] high_thr_q;
	logic [2:0] irq_en_q;
	logic [2:0] raw_q;
	logic [15:0] result_q;
	logic cmp_pending_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic access;
	logic wr;
	logic rd;
	logic [31:0] rdata_d;
	logic hit_d;
	logic wr_ctl;
	logic rd_result;
	logic wr_clr;
	logic conflict;
	logic finish;
	logic [2:0] set_mask;
	logic [2:0] clr_mask;

	ccc_conv_if conv ();

	// access phase completes on the edge where pready is high
	assign access = psel && penable && pready_q;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign wr_ctl = wr && (paddr == ccc_pkg::ADDR_CONTROL);
	assign rd_result = rd && (paddr == ccc_pkg::ADDR_RESULT);
	assign wr_clr = wr && (paddr == ccc_pkg::ADDR_IRQ_CLEAR);
	// same pair selected in both matrices
	assign conflict = |(matrix_a_q & matrix_b_q);

	// read data mux, reserved bits read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit_d = 1'b1;
		case (paddr)
			ccc_pkg::ADDR_CONTROL: begin
				rdata_d[ccc_pkg::CTL_START_BIT] = start_q;
				rdata_d[ccc_pkg::CTL_STOP_BIT] = stop_q;
				rdata_d[ccc_pkg::CTL_MODE_BIT] = mode_q;
			end
			ccc_pkg::ADDR_RESULT: rdata_d[15:0] = result_q;
			ccc_pkg::ADDR_STATE: rdata_d[ccc_pkg::STATE_CONFLICT_BIT] = conflict;
			ccc_pkg::ADDR_RES_SETUP: rdata_d[ccc_pkg::RES_LSB +: ccc_pkg::RES_W] = res_q;
			ccc_pkg::ADDR_OFFSET_SETUP: rdata_d[5:0] = offset_q;
			ccc_pkg::ADDR_RANGE_SETUP: rdata_d[1:0] = range_q;
			ccc_pkg::ADDR_MATRIX_A: rdata_d[16:0] = matrix_a_q;
			ccc_pkg::ADDR_MATRIX_B: rdata_d[16:0] = matrix_b_q;
			ccc_pkg::ADDR_LOW_THR: rdata_d[15:0] = low_thr_q;
			ccc_pkg::ADDR_HIGH_THR: rdata_d[15:0] = high_thr_q;
			ccc_pkg::ADDR_IRQ_ENABLE: rdata_d[2:0] = irq_en_q;
			ccc_pkg::ADDR_IRQ_RAW: rdata_d[2:0] = raw_q;
			ccc_pkg::ADDR_IRQ_ENABLED: rdata_d[2:0] = raw_q & irq_en_q;
			ccc_pkg::ADDR_IRQ_CLEAR: rdata_d = 32'h0000_0000;
			default: hit_d = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// apb handshake: one wait state, answer registered
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
				pslverr_q <= !hit_d;
			end else begin
				prdata_q <= 32'h0000_0000;
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// a software write of start wins over the self-clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			start_q <= ccc_pkg::RST_CONTROL[ccc_pkg::CTL_START_BIT];
			stop_q <= ccc_pkg::RST_CONTROL[ccc_pkg::CTL_STOP_BIT];
			mode_q <= ccc_pkg::RST_CONTROL[ccc_pkg::CTL_MODE_BIT];
		end else if (wr_ctl) begin
			start_q <= pwdata[ccc_pkg::CTL_START_BIT] || (start_q && !finish);
			// stop is only taken with continuous mode selected
			stop_q <= pwdata[ccc_pkg::CTL_MODE_BIT] && pwdata[ccc_pkg::CTL_STOP_BIT];
			mode_q <= pwdata[ccc_pkg::CTL_MODE_BIT];
		end else if (finish) begin
			start_q <= 1'b0;
			stop_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// setup, matrix and threshold registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			res_q <= ccc_pkg::RST_RES;
			offset_q <= ccc_pkg::RST_OFFSET;
			range_q <= ccc_pkg::RST_RANGE;
		end else if (wr) begin
			if (paddr == ccc_pkg::ADDR_RES_SETUP) res_q <= pwdata[ccc_pkg::RES_LSB +: ccc_pkg::RES_W];
			if (paddr == ccc_pkg::ADDR_OFFSET_SETUP) offset_q <= pwdata[5:0];
			if (paddr == ccc_pkg::ADDR_RANGE_SETUP) range_q <= pwdata[1:0];
		end
	end

	// input pair selections, one bit per pair
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			matrix_a_q <= ccc_pkg::RST_MATRIX;
			matrix_b_q <= ccc_pkg::RST_MATRIX;
		end else if (wr) begin
			if (paddr == ccc_pkg::ADDR_MATRIX_A) matrix_a_q <= pwdata[16:0];
			if (paddr == ccc_pkg::ADDR_MATRIX_B) matrix_b_q <= pwdata[16:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			low_thr_q <= ccc_pkg::RST_THR;
			high_thr_q <= ccc_pkg::RST_THR;
			irq_en_q <= ccc_pkg::RST_IRQ;
		end else if (wr) begin
			if (paddr == ccc_pkg::ADDR_LOW_THR) low_thr_q <= pwdata[15:0];
			if (paddr == ccc_pkg::ADDR_HIGH_THR) high_thr_q <= pwdata[15:0];
			if (paddr == ccc_pkg::ADDR_IRQ_ENABLE) irq_en_q <= pwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// conversion engine
	// ----------------------------------------------------------------
	ccc_seq u_seq (
		.core_clk(core_clk),
		.resetn(resetn),
		.start(start_q),
		.stop(stop_q),
		.mode(mode_q),
		.conflict(conflict),
		.res_code(res_q),
		.finish(finish),
		.conv(conv.seq)
	);

	ccc_accum u_accum (
		.core_clk(core_clk),
		.resetn(resetn),
		.mod_bit(mod_bit),
		.conv(conv.acc)
	);

	// result loaded with ready; thresholds compared one cycle later
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			result_q <= 16'h0000;
			cmp_pending_q <= 1'b0;
		end else begin
			cmp_pending_q <= conv.done;
			if (conv.done) begin
				result_q <= conv.result;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt conditions
	// ----------------------------------------------------------------
	always_comb begin
		set_mask = 3'h0;
		set_mask[ccc_pkg::IRQ_READY_BIT] = conv.done;
		set_mask[ccc_pkg::IRQ_LOW_BIT] = cmp_pending_q && (result_q < low_thr_q);
		set_mask[ccc_pkg::IRQ_HIGH_BIT] = cmp_pending_q && (result_q > high_thr_q);
		clr_mask = 3'h0;
		if (rd_result) begin
			clr_mask = 3'h7;
		end else if (wr_clr) begin
			clr_mask = pwdata[2:0];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			raw_q <= ccc_pkg::RST_IRQ;
		end else begin
			raw_q <= (raw_q & ~clr_mask) | set_mask;
		end
	end

	// level interrupt while an enabled condition stands
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(raw_q & irq_en_q);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign port_a_sel = matrix_a_q;
	assign port_b_sel = matrix_b_q;
	assign offset_cap = offset_q;
	assign range_cap = range_q;
	assign conv_busy = conv.busy;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_finish_quiet;
		finish && !wr_ctl;
	endsequence

	property p_start_self_clear;
		@(posedge core_clk) disable iff (!resetn)
		s_finish_quiet |=> !start_q;
	endproperty
	a_start_self_clear: assert property (p_start_self_clear) else $error("start not cleared");

	property p_stop_waits;
		@(posedge core_clk) disable iff (!resetn)
		(conv.busy && !conv.done && mode_q && stop_q && !wr_ctl) |=> (start_q && stop_q);
	endproperty
	a_stop_waits: assert property (p_stop_waits) else $error("stop acted mid conversion");

	property p_stop_ignored_single;
		@(posedge core_clk) disable iff (!resetn)
		(wr_ctl && !pwdata[ccc_pkg::CTL_MODE_BIT]) |=> !stop_q;
	endproperty
	a_stop_ignored_single: assert property (p_stop_ignored_single) else $error("stop kept in single");

	property p_continuous_relaunch;
		@(posedge core_clk) disable iff (!resetn)
		(conv.done && mode_q && !stop_q && !conflict) |-> conv.launch ##1 conv.busy;
	endproperty
	a_continuous_relaunch: assert property (p_continuous_relaunch) else $error("no relaunch");

	property p_result_read_clears;
		@(posedge core_clk) disable iff (!resetn)
		(rd_result && !conv.done && !cmp_pending_q) |=> (raw_q == 3'h0);
	endproperty
	a_result_read_clears: assert property (p_result_read_clears) else $error("read kept flags");

	property p_conflict_refuses;
		@(posedge core_clk) disable iff (!resetn)
		conflict |-> !conv.launch;
	endproperty
	a_conflict_refuses: assert property (p_conflict_refuses) else $error("launch under conflict");

	sequence s_result_loaded;
		raw_q[ccc_pkg::IRQ_READY_BIT] && cmp_pending_q;
	endsequence

	property p_ready_then_compare;
		@(posedge core_clk) disable iff (!resetn)
		conv.done |=> s_result_loaded and (result_q == $past(conv.result));
	endproperty
	a_ready_then_compare: assert property (p_ready_then_compare) else $error("result/ready order");

	property p_irq_follows;
		@(posedge core_clk) disable iff (!resetn)
		(|(raw_q & irq_en_q)) |=> irq_q;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

	property p_clear_write;
		@(posedge core_clk) disable iff (!resetn)
		(wr_clr && pwdata[ccc_pkg::IRQ_READY_BIT] && !conv.done) |=> !raw_q[ccc_pkg::IRQ_READY_BIT];
	endproperty
	a_clear_write: assert property (p_clear_write) else $error("clear write ignored");
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic mod_bit = 1'b0;
	logic mod_alt = 1'b0;
	logic mod_hold = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [16:0] port_a_sel;
	logic [16:0] port_b_sel;
	logic [5:0] offset_cap;
	logic [1:0] range_cap;
	logic conv_busy;
	logic irq;
	int n_errors = 0;
	int checks_done = 0;

	ccc_ctrl u_ccc_ctrl (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit),
		.port_a_sel(port_a_sel), .port_b_sel(port_b_sel), .offset_cap(offset_cap), .range_cap(range_cap),
		.conv_busy(conv_busy), .irq(irq));

	// clock, 8 ns period
	initial begin
		forever #4 core_clk = ~core_clk;
	end

	// alternating modulator stream gives half density
	always @(posedge core_clk) begin
		if (mod_alt) begin
			mod_bit <= ~mod_bit;
		end else begin
			mod_bit <= mod_hold;
		end
	end

	// ----------------------------------------------------------------
	// bus and check helpers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// request held until pready is sampled high at a rising edge
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (n >= 50) begin
			n_errors++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK(q, exp)
		`CHK(e, 1'b0)
	endtask

	// waits for a conversion and checks how long it counted
	task automatic conv_len(input int exp);
		int n;
		n = 0;
		while (conv_busy !== 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (conv_busy === 1'b1 && n < 70000) begin
			@(negedge core_clk);
			n++;
		end
		`CHK(n, exp)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_map();
		logic [31:0] q;
		logic e;
		for (int a = 0; a <= 'h34; a += 4) begin
			rd_chk(12'(a), 32'h0000_0000);
		end
		apb(1'b0, 12'h038, 32'h0000_0000, q, e);
		`CHK(e, 1'b1)
		wr(ccc_pkg::ADDR_STATE, 32'hffff_ffff);
		rd_chk(ccc_pkg::ADDR_STATE, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			wr(ccc_pkg::ADDR_RES_SETUP, {28'hfff_ffff, 3'(c), 1'b1});
			rd_chk(ccc_pkg::ADDR_RES_SETUP, {28'h000_0000, 3'(c), 1'b0});
		end
		wr(ccc_pkg::ADDR_OFFSET_SETUP, 32'h0000_003f);
		wr(ccc_pkg::ADDR_RANGE_SETUP, 32'h0000_0003);
		@(negedge core_clk);
		`CHK({offset_cap, range_cap}, 8'hff)
	endtask

	task automatic t_single_irq();
		mod_hold <= 1'b1;
		wr(ccc_pkg::ADDR_RES_SETUP, 32'h0000_0000);
		wr(ccc_pkg::ADDR_LOW_THR, 32'h0000_0200);
		wr(ccc_pkg::ADDR_HIGH_THR, 32'h0000_0080);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0001);
		conv_len(256);
		rd_chk(ccc_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(ccc_pkg::ADDR_IRQ_RAW, 32'h0000_0007);
		rd_chk(ccc_pkg::ADDR_IRQ_ENABLED, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(ccc_pkg::ADDR_IRQ_ENABLE, 32'h0000_0004);
		rd_chk(ccc_pkg::ADDR_IRQ_ENABLED, 32'h0000_0004);
		`CHK(irq, 1'b1)
		wr(ccc_pkg::ADDR_IRQ_CLEAR, 32'h0000_0002);
		rd_chk(ccc_pkg::ADDR_IRQ_RAW, 32'h0000_0005);
		rd_chk(ccc_pkg::ADDR_IRQ_CLEAR, 32'h0000_0000);
		rd_chk(ccc_pkg::ADDR_RESULT, 32'h0000_0100);
		rd_chk(ccc_pkg::ADDR_IRQ_RAW, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(ccc_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000);
	endtask

	task automatic t_continuous();
		mod_alt <= 1'b1;
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0005);
		repeat (600) @(negedge core_clk);
		`CHK(conv_busy, 1'b1)
		rd_chk(ccc_pkg::ADDR_IRQ_RAW, 32'h0000_0003);
		rd_chk(ccc_pkg::ADDR_RESULT, 32'h0000_0080);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0007);
		`CHK(conv_busy, 1'b1)
		repeat (300) @(negedge core_clk);
		`CHK(conv_busy, 1'b0)
		rd_chk(ccc_pkg::ADDR_CONTROL, 32'h0000_0004);
		rd_chk(ccc_pkg::ADDR_RESULT, 32'h0000_0080);
	endtask

	task automatic t_conflict();
		mod_alt <= 1'b0;
		mod_hold <= 1'b1;
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(ccc_pkg::ADDR_MATRIX_A, 32'h0001_0001);
		wr(ccc_pkg::ADDR_MATRIX_B, 32'hfffe_0801);
		@(negedge core_clk);
		`CHK({port_a_sel, port_b_sel}, {17'h1_0001, 17'h0_0801})
		rd_chk(ccc_pkg::ADDR_MATRIX_B, 32'h0000_0801);
		rd_chk(ccc_pkg::ADDR_STATE, 32'h0000_0080);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0003);
		rd_chk(ccc_pkg::ADDR_CONTROL, 32'h0000_0001);
		repeat (300) @(negedge core_clk);
		`CHK(conv_busy, 1'b0)
		wr(ccc_pkg::ADDR_MATRIX_B, 32'h0000_0800);
		conv_len(256);
		rd_chk(ccc_pkg::ADDR_STATE, 32'h0000_0000);
		rd_chk(ccc_pkg::ADDR_CONTROL, 32'h0000_0000);
	endtask

	task automatic t_resolution();
		mod_alt <= 1'b1;
		wr(ccc_pkg::ADDR_RES_SETUP, 32'h0000_0002);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0001);
		conv_len(1024);
		rd_chk(ccc_pkg::ADDR_RESULT, 32'h0000_0200);
		wr(ccc_pkg::ADDR_RES_SETUP, 32'h0000_0004);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0001);
		conv_len(2048);
		mod_alt <= 1'b0;
		mod_hold <= 1'b1;
		wr(ccc_pkg::ADDR_RES_SETUP, 32'h0000_000e);
		wr(ccc_pkg::ADDR_CONTROL, 32'h0000_0001);
		conv_len(65536);
		rd_chk(ccc_pkg::ADDR_RESULT, 32'h0000_ffff);
	endtask

	// ----------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// a hang counts as a mismatch
	initial begin
		repeat (95000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset_map();
		t_single_irq();
		t_continuous();
		t_conflict();
		t_resolution();
		give_verdict();
	end
endmodule
